// File: hdl/dhtf_pkg.sv
package dhtf_pkg;
    // three-bit register codes inside each select window
    localparam logic [2:0] DHTF_A_DATA = 3'h0;
    localparam logic [2:0] DHTF_A_ERR = 3'h1;
    localparam logic [2:0] DHTF_A_COUNT = 3'h2;
    localparam logic [2:0] DHTF_A_SECTOR = 3'h3;
    localparam logic [2:0] DHTF_A_CYL_LO = 3'h4;
    localparam logic [2:0] DHTF_A_CYL_HI = 3'h5;
    localparam logic [2:0] DHTF_A_DRVHD = 3'h6;
    localparam logic [2:0] DHTF_A_STATUS = 3'h7;
    localparam logic [2:0] DHTF_A_ALT_STATUS = 3'h6;
    localparam logic [2:0] DHTF_A_DIGIN = 3'h7;
    // status bit positions
    localparam int DHTF_ST_BUSY = 7;
    localparam int DHTF_ST_READY = 6;
    localparam int DHTF_ST_FAULT = 5;
    localparam int DHTF_ST_SEEK = 4;
    localparam int DHTF_ST_DATA_REQUEST_FLAG = 3;
    localparam int DHTF_ST_CORRECTED_ECC_FLAG = 2;
    localparam int DHTF_ST_INDEX = 1;
    localparam int DHTF_ST_ERROR = 0;
    // drive/head fields
    localparam int DHTF_DH_DRV = 4;
    localparam int DHTF_DH_HEAD3 = 3;
    localparam logic [7:0] DHTF_DH_RST = 8'h00;
    // fixed-disk control bits
    localparam int DHTF_FD_RESET = 2;
    localparam int DHTF_FD_IRQ_DIS = 1;
    localparam logic [7:0] DHTF_CMD_DIAG = 8'h90;
    localparam logic [7:0] DHTF_REG_RST = 8'h00;
    localparam logic [8:0] DHTF_FULL_COUNT = 9'h100;
    localparam int DHTF_DATA_W = 16;
    localparam int DHTF_FIFO_DEPTH = 16;

    typedef struct packed {
        logic hit_task;
        logic hit_ctl;
        logic [2:0] code;
    } dhtf_sel_t;

    typedef struct packed {
        logic cs0_n;
        logic a9_cs1;
        logic [2:0] addr;
        logic ior_n;
        logic iow_n;
        logic dack_n;
        logic hrst;
        logic [15:0] data;
    } dhtf_pins_t;

    typedef struct packed {
        logic [7:0] error;
        logic [7:0] precomp;
        logic [7:0] count;
        logic [7:0] sector;
        logic [7:0] cyl_lo;
        logic [7:0] cyl_hi;
        logic [7:0] drvhd;
        logic [7:0] command;
    } dhtf_taskfile_t;

    typedef struct packed {
        logic err_load;
        logic [7:0] err_code;
        logic busy_clr;
        logic data_request_flag_set;
        logic data_request_flag_clr;
        logic ecc_phase;
        logic corr_set;
        logic cnt_dec;
        logic sec_inc;
        logic irq_raise;
    } dhtf_mcu_t;

    typedef struct packed {
        logic ready;
        logic fault;
        logic seek_done;
        logic index;
        logic wgate;
    } dhtf_drive_t;

    typedef enum logic [2:0] {
        DHTF_IDLE = 3'b001,
        DHTF_WAIT = 3'b010,
        DHTF_HOLD = 3'b100
    } dhtf_state_t;
endpackage : dhtf_pkg

// File: hdl/dhtf_port.sv
// Operation
// - registers answer only while host type select bit is clear.
// - shared pin as line nine: low selects task file, high alternate pair.
// - shared pin as second select: selects task file or alternate pair.
// - while busy without data request, task reads give status; host writes only control registers.
// - data port moves 16-bit words, 8-bit during ECC bytes.
// - error code loaded by controller sets error; command write clears it.
// - sector count zero means 256; decremented by controller; access while not busy or during data request.
// - sector number advanced by one per sector by the controller.
// - cylinder low and high bytes form one 16-bit cylinder.
// - drive/head holds size, drive bit, head; bit seven written one.
// - drive/head cleared by local, host, fixed-disk reset or diagnostic command.
// - primary status read clears pending host interrupt; readable any time.
// - status layout busy, ready, fault, seek, data_request_flag, corrected, index, error.
// - index bit follows drive index, forced low without drive ready.
// - corrected bit set by controller, cleared on command write.
// - ready, fault, seek done follow the selected drive.
// - busy set by resets, fixed-disk reset bit and command load.
// - during data request every task register is reachable, command too.
// - alternate status same layout, read leaves interrupt pending.
// - fixed-disk reset bit holds the host interface in reset.
// - host interrupt driven only while interrupt disable bit is zero.
`timescale 1ns/1ps
module dhtf_fifo #(
    parameter int WIDTH = 17,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // fill side
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    // drain side
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
    logic [AW:0] cnt_q, cnt_d;
    logic full_q, full_d, empty_q, empty_d;
    logic push, pop;

    always_comb begin
        push = in_valid & ~full_q;
        pop = out_ready & ~empty_q;
        wp_d = push ? wp_q + 1'b1 : wp_q;
        rp_d = pop ? rp_q + 1'b1 : rp_q;
        cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        full_d = cnt_d == (AW+1)'(DEPTH);
        empty_d = cnt_d == '0;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
            full_q <= 1'b0;
            empty_q <= 1'b1;
        end else begin
            wp_q <= wp_d;
            rp_q <= rp_d;
            cnt_q <= cnt_d;
            full_q <= full_d;
            empty_q <= empty_d;
        end
    end

    // storage needs no reset
    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wp_q] <= in_data;
        end
    end

    assign in_ready = ~full_q;
    assign out_valid = ~empty_q;
    assign out_data = mem[rp_q];
endmodule : dhtf_fifo

module dhtf_port (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // host pins
    input wire logic primary_chip_select_n,
    input wire logic address_line_nine,
    input wire logic [2:0] host_addr,
    input wire logic host_ior_n,
    input wire logic host_iow_n,
    input wire logic host_dack_n,
    input wire logic host_reset_line,
    input wire logic [15:0] host_data_i,
    output logic [15:0] host_data_o,
    output logic host_data_oe,
    output logic host_io_ready,
    output logic host_dma_req,
    output logic host_irq_o,
    output logic host_irq_oe,
    // mode straps from local configuration
    input wire logic host_type_select_bit,
    input wire logic second_cs_enable,
    // local controller side
    input wire dhtf_pkg::dhtf_mcu_t mcu,
    input wire dhtf_pkg::dhtf_drive_t drive,
    output dhtf_pkg::dhtf_taskfile_t taskfile,
    output logic [8:0] sectors_to_move,
    output logic command_strobe,
    output logic host_irq_pending,
    // buffer side, host writes
    output logic buf_wr_valid,
    output logic [16:0] buf_wr_data,
    input wire logic buf_wr_ready,
    // buffer side, host reads
    input wire logic buf_rd_valid,
    input wire logic [15:0] buf_rd_data,
    output logic buf_rd_ready
);
    localparam int FW = dhtf_pkg::DHTF_DATA_W + 1;

    function automatic dhtf_pkg::dhtf_sel_t decode(input logic cs0_n, input logic pin48,
                                                    input logic cs1_mode, input logic [2:0] a);
        dhtf_pkg::dhtf_sel_t s;
        s.code = a;
        if (cs1_mode) begin
            s.hit_task = !cs0_n && pin48;
            s.hit_ctl = cs0_n && !pin48 && a[2:1] == 2'b11;
        end else begin
            s.hit_task = !cs0_n && !pin48;
            s.hit_ctl = !cs0_n && pin48 && a[2:1] == 2'b11;
        end
        return s;
    endfunction : decode

    // three-stage pin sampling with agreement filter
    dhtf_pkg::dhtf_pins_t raw, s1_q, s2_q, s3_q, f_q, f_d, fp_q;
    always_comb begin
        raw = '0;
        raw.ior_n = host_ior_n;
        raw.cs0_n = primary_chip_select_n;
        raw.a9_cs1 = address_line_nine;
        raw.addr = host_addr;
        raw.iow_n = host_iow_n;
        raw.dack_n = host_dack_n;
        raw.hrst = host_reset_line;
        raw.data = host_data_i;
        f_d = (s3_q & ~(s2_q ^ s3_q)) | (f_q & (s2_q ^ s3_q));
    end
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= '1;
            s2_q <= '1;
            s3_q <= '1;
            f_q <= '1;
            fp_q <= '1;
        end else begin
            s1_q <= raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
            f_q <= f_d;
            fp_q <= f_q;
        end
    end

    // fifos in the data path
    logic wf_valid, wf_ready, rf_valid, rf_ready;
    logic [FW-1:0] wf_data;
    logic [FW-2:0] rf_data;
    dhtf_fifo #(.WIDTH(FW), .DEPTH(dhtf_pkg::DHTF_FIFO_DEPTH)) u_wr_fifo (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .in_valid(wf_valid),
        .in_data(wf_data),
        .in_ready(wf_ready),
        .out_valid(buf_wr_valid),
        .out_data(buf_wr_data),
        .out_ready(buf_wr_ready)
    );
    dhtf_fifo #(.WIDTH(FW - 1), .DEPTH(dhtf_pkg::DHTF_FIFO_DEPTH)) u_rd_fifo (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .in_valid(buf_rd_valid),
        .in_data(buf_rd_data),
        .in_ready(buf_rd_ready),
        .out_valid(rf_valid),
        .out_data(rf_data),
        .out_ready(rf_ready)
    );

    // host-side state
    dhtf_pkg::dhtf_state_t st_q, st_d;
    dhtf_pkg::dhtf_taskfile_t tf_q, tf_d;
    logic busy_q, busy_d, data_request_flag_q, data_request_flag_d, err_q, err_d, corr_q, corr_d;
    logic irq_q, irq_d, fd_rst_q, fd_rst_d, irq_dis_q, irq_dis_d;
    logic [15:0] dout_q, dout_d;
    logic oe_q, oe_d, rdy_q, rdy_d, cmd_q, cmd_d, dma_q, dma_d;
    logic [8:0] total_q, total_d;
    logic acc_rd, acc_wr, is_rd_q, is_rd_d, data_sel, host_rst, cmd_wr, stat_rd;
    logic [7:0] status, digin, wdata8;
    dhtf_pkg::dhtf_sel_t sel;

    always_comb begin
        sel = decode(f_q.cs0_n, f_q.a9_cs1, second_cs_enable, f_q.addr);
        host_rst = f_q.hrst | fd_rst_q;
        acc_rd = fp_q.ior_n & ~f_q.ior_n & ~host_type_select_bit;
        acc_wr = fp_q.iow_n & ~f_q.iow_n & ~host_type_select_bit;
        data_sel = ~f_q.dack_n | (sel.hit_task && sel.code == dhtf_pkg::DHTF_A_DATA);
        wdata8 = f_q.data[7:0];
        status = {busy_q, drive.ready, drive.fault, drive.seek_done, data_request_flag_q, corr_q,
                  drive.index & drive.ready, err_q};
        digin = {1'b0, ~drive.wgate, ~tf_q.drvhd[dhtf_pkg::DHTF_DH_HEAD3:0],
                 ~tf_q.drvhd[dhtf_pkg::DHTF_DH_DRV], tf_q.drvhd[dhtf_pkg::DHTF_DH_DRV]};
        st_d = st_q;
        tf_d = tf_q;
        busy_d = busy_q;
        data_request_flag_d = data_request_flag_q;
        err_d = err_q;
        corr_d = corr_q;
        irq_d = irq_q;
        fd_rst_d = fd_rst_q;
        irq_dis_d = irq_dis_q;
        dout_d = dout_q;
        oe_d = oe_q;
        rdy_d = rdy_q;
        is_rd_d = is_rd_q;
        cmd_wr = 1'b0;
        stat_rd = 1'b0;
        wf_valid = 1'b0;
        wf_data = {mcu.ecc_phase, mcu.ecc_phase ? {8'h00, wdata8} : f_q.data};
        rf_ready = 1'b0;
        case (st_q)
            dhtf_pkg::DHTF_IDLE: begin
                if ((acc_rd || acc_wr) && data_sel && !(sel.hit_ctl)) begin
                    // data port is only meaningful while a transfer is requested
                    is_rd_d = acc_rd;
                    if (data_request_flag_q) begin
                        st_d = dhtf_pkg::DHTF_WAIT;
                        rdy_d = 1'b0;
                    end else begin
                        st_d = dhtf_pkg::DHTF_HOLD;
                        oe_d = acc_rd;
                        dout_d = {8'h00, status};
                    end
                end else if (acc_rd && (sel.hit_task || sel.hit_ctl)) begin
                    st_d = dhtf_pkg::DHTF_HOLD;
                    oe_d = 1'b1;
                    dout_d = 16'h0000;
                    if (sel.hit_ctl) begin
                        dout_d[7:0] = sel.code == dhtf_pkg::DHTF_A_ALT_STATUS ? status : digin;
                    end else if (busy_q && !data_request_flag_q) begin
                        dout_d[7:0] = status;
                        stat_rd = 1'b1;
                    end else begin
                        case (sel.code)
                            dhtf_pkg::DHTF_A_ERR: dout_d[7:0] = tf_q.error;
                            dhtf_pkg::DHTF_A_COUNT: dout_d[7:0] = tf_q.count;
                            dhtf_pkg::DHTF_A_SECTOR: dout_d[7:0] = tf_q.sector;
                            dhtf_pkg::DHTF_A_CYL_LO: dout_d[7:0] = tf_q.cyl_lo;
                            dhtf_pkg::DHTF_A_CYL_HI: dout_d[7:0] = tf_q.cyl_hi;
                            dhtf_pkg::DHTF_A_DRVHD: dout_d[7:0] = tf_q.drvhd;
                            default: begin
                                dout_d[7:0] = status;
                                stat_rd = 1'b1;
                            end
                        endcase
                    end
                end else if (acc_wr && sel.hit_ctl) begin
                    st_d = dhtf_pkg::DHTF_HOLD;
                    if (sel.code == dhtf_pkg::DHTF_A_ALT_STATUS) begin
                        fd_rst_d = wdata8[dhtf_pkg::DHTF_FD_RESET];
                        irq_dis_d = wdata8[dhtf_pkg::DHTF_FD_IRQ_DIS];
                    end
                end else if (acc_wr && sel.hit_task) begin
                    st_d = dhtf_pkg::DHTF_HOLD;
                    // a busy controller ignores task writes unless it asks for data
                    if (!busy_q || data_request_flag_q) begin
                        case (sel.code)
                            dhtf_pkg::DHTF_A_ERR: tf_d.precomp = wdata8;
                            dhtf_pkg::DHTF_A_COUNT: tf_d.count = wdata8;
                            dhtf_pkg::DHTF_A_SECTOR: tf_d.sector = wdata8;
                            dhtf_pkg::DHTF_A_CYL_LO: tf_d.cyl_lo = wdata8;
                            dhtf_pkg::DHTF_A_CYL_HI: tf_d.cyl_hi = wdata8;
                            dhtf_pkg::DHTF_A_DRVHD: tf_d.drvhd = wdata8;
                            default: begin
                                tf_d.command = wdata8;
                                cmd_wr = 1'b1;
                            end
                        endcase
                    end
                end
            end
            dhtf_pkg::DHTF_WAIT: begin
                // host is held off through the ready line until the fifo can move
                if (is_rd_q && rf_valid) begin
                    rf_ready = 1'b1;
                    dout_d = mcu.ecc_phase ? {8'h00, rf_data[7:0]} : rf_data;
                    oe_d = 1'b1;
                    rdy_d = 1'b1;
                    st_d = dhtf_pkg::DHTF_HOLD;
                end else if (!is_rd_q && wf_ready) begin
                    wf_valid = 1'b1;
                    rdy_d = 1'b1;
                    st_d = dhtf_pkg::DHTF_HOLD;
                end
            end
            dhtf_pkg::DHTF_HOLD: begin
                if (f_q.ior_n && f_q.iow_n) begin
                    oe_d = 1'b0;
                    st_d = dhtf_pkg::DHTF_IDLE;
                end
            end
            default: st_d = dhtf_pkg::DHTF_IDLE;
        endcase
        // controller-side updates
        if (mcu.cnt_dec) begin
            tf_d.count = tf_q.count - 8'h01;
        end
        if (mcu.sec_inc) begin
            tf_d.sector = tf_q.sector + 8'h01;
        end
        if (mcu.err_load) begin
            tf_d.error = mcu.err_code;
        end
        if (mcu.busy_clr) begin
            busy_d = 1'b0;
        end
        if (mcu.data_request_flag_clr) begin
            data_request_flag_d = 1'b0;
        end
        if (mcu.data_request_flag_set) begin
            data_request_flag_d = 1'b1;
        end
        if (cmd_wr) begin
            busy_d = 1'b1;
            err_d = 1'b0;
            corr_d = 1'b0;
            if (wdata8 == dhtf_pkg::DHTF_CMD_DIAG) begin
                tf_d.drvhd = dhtf_pkg::DHTF_DH_RST;
            end
        end
        // sets after clears so a same-cycle event survives, except against a host reset, applied last
        if (mcu.err_load) begin
            err_d = 1'b1;
        end
        if (mcu.corr_set) begin
            corr_d = 1'b1;
        end
        if (stat_rd) begin
            irq_d = 1'b0;
        end
        if (mcu.irq_raise) begin
            irq_d = 1'b1;
        end
        if (host_rst) begin
            tf_d.drvhd = dhtf_pkg::DHTF_DH_RST;
            busy_d = 1'b1;
            data_request_flag_d = 1'b0;
            irq_d = 1'b0;
        end
        total_d = tf_d.count == 8'h00 ? dhtf_pkg::DHTF_FULL_COUNT : {1'b0, tf_d.count};
        cmd_d = cmd_wr;
        dma_d = data_request_flag_d & ~host_type_select_bit;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= dhtf_pkg::DHTF_IDLE;
            tf_q <= '{default: dhtf_pkg::DHTF_REG_RST};
            busy_q <= 1'b1;
            data_request_flag_q <= 1'b0;
            err_q <= 1'b0;
            corr_q <= 1'b0;
            irq_q <= 1'b0;
            fd_rst_q <= 1'b0;
            irq_dis_q <= 1'b0;
            dout_q <= 16'h0000;
            oe_q <= 1'b0;
            rdy_q <= 1'b1;
            is_rd_q <= 1'b0;
            cmd_q <= 1'b0;
            dma_q <= 1'b0;
            total_q <= dhtf_pkg::DHTF_FULL_COUNT;
        end else begin
            st_q <= st_d;
            tf_q <= tf_d;
            busy_q <= busy_d;
            data_request_flag_q <= data_request_flag_d;
            err_q <= err_d;
            corr_q <= corr_d;
            irq_q <= irq_d;
            fd_rst_q <= fd_rst_d;
            irq_dis_q <= irq_dis_d;
            dout_q <= dout_d;
            oe_q <= oe_d;
            rdy_q <= rdy_d;
            is_rd_q <= is_rd_d;
            cmd_q <= cmd_d;
            dma_q <= dma_d;
            total_q <= total_d;
        end
    end

    // interrupt pin released while disabled, pending state kept
    logic irq_o_q, irq_oe_q;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_o_q <= 1'b0;
            irq_oe_q <= 1'b0;
        end else begin
            irq_o_q <= irq_d;
            irq_oe_q <= ~irq_dis_d & ~host_type_select_bit;
        end
    end

    assign host_data_o = dout_q;
    assign host_data_oe = oe_q;
    assign host_io_ready = rdy_q;
    assign host_dma_req = dma_q;
    assign host_irq_o = irq_o_q;
    assign host_irq_oe = irq_oe_q;
    assign taskfile = tf_q;
    assign sectors_to_move = total_q;
    assign command_strobe = cmd_q;
    assign host_irq_pending = irq_q;

    sequence s_cmd_write;
        st_q == dhtf_pkg::DHTF_IDLE && acc_wr && sel.hit_task && (!busy_q || data_request_flag_q)
            && sel.code == dhtf_pkg::DHTF_A_STATUS && !data_sel;
    endsequence
    sequence s_status_read;
        stat_rd && !mcu.irq_raise;
    endsequence

    a_cmd_sets_busy: assert property (@(posedge ref_clk) disable iff (!rst_n)
        s_cmd_write |=> busy_q && command_strobe) else $error("command did not set busy");
    a_cmd_clears_err: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (s_cmd_write and !mcu.err_load) |=> !status[0]) else $error("error kept over command");
    a_cmd_clears_corr: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (s_cmd_write and !mcu.corr_set) |=> !corr_q) else $error("corrected kept over command");
    a_status_read_irq: assert property (@(posedge ref_clk) disable iff (!rst_n)
        s_status_read |=> !host_irq_pending) else $error("status read left irq pending");
    a_alt_keeps_irq: assert property (@(posedge ref_clk) disable iff (!rst_n)
        acc_rd && sel.hit_ctl && irq_q && !host_rst |=> host_irq_pending)
        else $error("alternate status cleared irq");
    a_index_gated: assert property (@(posedge ref_clk) disable iff (!rst_n)
        stat_rd && !drive.ready |=> !host_data_o[1]) else $error("index shown without ready");
    a_busy_read_status: assert property (@(posedge ref_clk) disable iff (!rst_n)
        st_q == dhtf_pkg::DHTF_IDLE && acc_rd && sel.hit_task && !data_sel && busy_q && !data_request_flag_q
        |=> oe_q && dout_q[7] == 1'b1) else $error("busy read did not return status");
    a_busy_write_drop: assert property (@(posedge ref_clk) disable iff (!rst_n)
        st_q == dhtf_pkg::DHTF_IDLE && acc_wr && sel.hit_task && busy_q && !data_request_flag_q
        && !mcu.cnt_dec && !mcu.sec_inc && !host_rst |=> $stable(taskfile.count)
        && $stable(taskfile.drvhd)) else $error("task write taken while busy");
    a_zero_count: assert property (@(posedge ref_clk) disable iff (!rst_n)
        taskfile.count == 8'h00 |-> sectors_to_move == dhtf_pkg::DHTF_FULL_COUNT)
        else $error("zero count not 256");
    a_reset_drvhd: assert property (@(posedge ref_clk) disable iff (!rst_n)
        host_rst |=> taskfile.drvhd == dhtf_pkg::DHTF_DH_RST && busy_q)
        else $error("host reset left drive/head");
    a_irq_disable: assert property (@(posedge ref_clk) disable iff (!rst_n)
        irq_dis_q ##1 irq_dis_q |-> !host_irq_oe) else $error("irq driven while disabled");
    a_off_mode: assert property (@(posedge ref_clk) disable iff (!rst_n)
        host_type_select_bit && st_q == dhtf_pkg::DHTF_IDLE |=> !host_data_oe)
        else $error("answered in alternate mode");
endmodule : dhtf_port

// File: test/dhtf_host_model.sv
`timescale 1ns/1ps
module dhtf_host_model (
    // clock
    input wire logic ref_clk,
    // host pins
    output logic cs_n,
    output logic a9,
    output logic [2:0] addr,
    output logic ior_n,
    output logic iow_n,
    output logic [15:0] wdata,
    // read data and cycle stretch
    input wire logic [15:0] rdata,
    input wire logic rdy
);
    initial {cs_n, a9, addr, ior_n, iow_n, wdata} = {7'h7f, 16'h0000};
    // strobe held past the pin filter; a released bus shows the inverse
    task automatic cycle(input logic wr, input logic alt, input logic [2:0] a,
        input logic [15:0] d, output logic [15:0] q);
        @(negedge ref_clk);
        {cs_n, a9, addr, ior_n, iow_n, wdata} = {1'b0, alt, a, wr, ~wr, d};
        repeat (8) @(negedge ref_clk);
        // strobe held while the port stretches the cycle
        for (int i = 0; i < 64 && !rdy; i++) @(negedge ref_clk);
        q = rdy ? rdata : 16'hxxxx;
        {cs_n, ior_n, iow_n, wdata} = {3'h7, ~d};
        repeat (8) @(negedge ref_clk);
    endtask : cycle
endmodule : dhtf_host_model

// File: test/dhtf_port_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin errors++; \
    $display("Error %s exp %h seen %h", n, e, s); end end
module dhtf_port_tb;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic cs_n, a9, ior_n, iow_n, wr_rdy, irq, irq_oe, wr_vld, pend;
    logic oe, io_rdy, dma, cmd_stb, rd_rdy;
    logic rd_vld = 1'b0;
    logic rd_took = 1'b0;
    logic xt = 1'b0;
    logic [2:0] addr;
    logic [15:0] wdata, rdata, rd_word, q;
    logic [16:0] wr_word;
    logic [8:0] to_move;
    logic [7:0] w;
    dhtf_pkg::dhtf_mcu_t mcu = '0;
    dhtf_pkg::dhtf_drive_t drive;
    dhtf_pkg::dhtf_taskfile_t tf;
    int errors = 0;
    int comparisons = 0;
    int seed = 87;
    int cmds = 0;
    int busy, err, data_request_flag;
    logic [16:0] got[$];
    // released data bus floats to its pull-up
    wire [15:0] bus = oe ? rdata : 16'hffff;
    always #25 ref_clk = ~ref_clk;
    // the buffer side holds its valid until the port has taken the word
    always @(negedge ref_clk) begin
        wr_rdy <= $random(seed);
        if (!rd_vld || rd_took) rd_vld <= $random(seed);
    end
    always @(posedge ref_clk) begin
        if (wr_vld && wr_rdy) got.push_back(wr_word);
        rd_took <= rd_vld && rd_rdy;
        if (cmd_stb) cmds++;
    end
    dhtf_host_model host (.ref_clk(ref_clk), .cs_n(cs_n), .a9(a9), .addr(addr),
        .ior_n(ior_n), .iow_n(iow_n), .wdata(wdata), .rdata(bus), .rdy(io_rdy));
    dhtf_port DUT (.ref_clk(ref_clk), .rst_n(rst_n), .primary_chip_select_n(cs_n),
        .address_line_nine(a9), .host_addr(addr), .host_ior_n(ior_n), .host_iow_n(iow_n),
        .host_dack_n(1'b1), .host_reset_line(1'b0), .host_data_i(wdata),
        .host_data_o(rdata), .host_data_oe(oe), .host_io_ready(io_rdy), .host_dma_req(dma),
        .host_irq_o(irq), .host_irq_oe(irq_oe), .host_type_select_bit(xt),
        .second_cs_enable(1'b0), .mcu(mcu), .drive(drive), .taskfile(tf),
        .sectors_to_move(to_move), .command_strobe(cmd_stb), .host_irq_pending(pend),
        .buf_wr_valid(wr_vld), .buf_wr_data(wr_word), .buf_wr_ready(wr_rdy),
        .buf_rd_valid(rd_vld), .buf_rd_data(rd_word), .buf_rd_ready(rd_rdy));
    function automatic logic [7:0] st();
        return {busy[0], drive.ready, drive.fault, drive.seek_done, data_request_flag[0], 1'b0,
            drive.index & drive.ready, err[0]};
    endfunction : st
    task automatic pulse(input logic [16:0] v);
        @(negedge ref_clk) mcu = v;
        @(negedge ref_clk) mcu = '0;
    endtask : pulse
    task automatic print_verdict();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : print_verdict
    initial begin
        repeat (20000) @(negedge ref_clk);
        errors++;
        print_verdict();
    end
    initial begin
        drive = $random(seed);
        rd_word = $random(seed);
        repeat (8) @(negedge ref_clk);
        rst_n = 1'b1;
        {busy, err, data_request_flag} = {32'd1, 32'd0, 32'd0};
        repeat (6) @(negedge ref_clk);
        host.cycle(0, 0, 3'h7, 0, q);
        `CHK("busy", 8'h80, q[7:0] & 8'h80)
        host.cycle(1, 0, 3'h2, 16'h0005, q);
        `CHK("count", 8'h00, tf.count)
        pulse(17'h00080);
        busy = 0;
        for (int i = 2; i < 7; i++) begin
            w = $random(seed) | 8'h81;
            host.cycle(1, 0, i[2:0], {8'h00, w}, q);
            host.cycle(0, 0, i[2:0], 0, q);
            `CHK("reg", w, q[7:0])
        end
        host.cycle(1, 0, 3'h1, 16'h0040, q);
        `CHK("precomp", 8'h40, tf.precomp)
        host.cycle(1, 0, 3'h2, 0, q);
        `CHK("to_move", 9'h100, to_move)
        pulse(17'h13c00);
        err = 1;
        host.cycle(0, 0, 3'h1, 0, q);
        `CHK("err", 8'h3c, q[7:0])
        host.cycle(0, 0, 3'h7, 0, q);
        `CHK("status", st(), q[7:0])
        host.cycle(1, 0, 3'h7, 16'h0090, q);
        {busy, err} = {32'd1, 32'd0};
        `CHK("drvhd", 8'h00, tf.drvhd)
        `CHK("cmd", 32'd1, cmds)
        pulse(17'h00080);
        busy = 0;
        host.cycle(0, 0, 3'h7, 0, q);
        `CHK("status", st(), q[7:0])
        pulse(17'h00001);
        `CHK("irq", 2'b11, {irq, irq_oe})
        host.cycle(0, 1, 3'h6, 0, q);
        `CHK("alt", {st(), 1'b1}, {q[7:0], pend})
        host.cycle(0, 0, 3'h7, 0, q);
        `CHK("pend", 1'b0, pend)
        host.cycle(0, 1, 3'h7, 0, q);
        `CHK("digin", {1'b0, ~drive.wgate, 6'h3e}, q[7:0])
        host.cycle(1, 1, 3'h6, 16'h0002, q);
        `CHK("irq_oe", 1'b0, irq_oe)
        host.cycle(1, 1, 3'h6, 16'h0004, q);
        host.cycle(1, 1, 3'h6, 0, q);
        busy = 1;
        host.cycle(0, 0, 3'h7, 0, q);
        `CHK("fd_reset", st(), q[7:0])
        xt = 1'b1;
        host.cycle(0, 0, 3'h7, 0, q);
        xt = 1'b0;
        `CHK("off", 16'hffff, q)
        pulse(17'h000c0);
        {busy, data_request_flag} = {32'd0, 32'd1};
        `CHK("dma", 1'b1, dma)
        host.cycle(1, 0, 3'h0, 16'h1234, q);
        for (int i = 0; i < 50 && got.size() == 0; i++) @(negedge ref_clk);
        `CHK("buf", 17'h01234, got[0])
        host.cycle(0, 0, 3'h0, 0, q);
        `CHK("rd", rd_word, q)
        host.cycle(0, 0, 3'h7, 0, q);
        `CHK("status", st(), q[7:0])
        mcu.ecc_phase = 1'b1;
        host.cycle(1, 0, 3'h0, 16'hab12, q);
        host.cycle(0, 0, 3'h0, 0, q);
        mcu.ecc_phase = 1'b0;
        for (int i = 0; i < 50 && got.size() < 2; i++) @(negedge ref_clk);
        `CHK("ecc_buf", 17'h10012, got[1])
        `CHK("ecc_rd", {8'h00, rd_word[7:0]}, q)
        print_verdict();
    end
endmodule : dhtf_port_tb
